/* tccs_pkg.sv */
// constants, field layouts and carrier types of the timer capture/control/status block
// assumes one bus clock domain and an ahb-lite master of whole aligned words
// How it works
// - each selected edge on the capture pin copies the counter into the 16-bit capture value.
// - captured value is one plus the count at the edge before the pin transition.
// - the copy happens on every qualifying edge, whether the capture flag is set or not.
// - reading the capture high byte blocks further copies, except a stop capture delivered at wake, until the low byte is read.
// - reading only the capture low byte never blocks a copy.
// - reset leaves the capture value untouched; it is undefined until the first capture.
// - control bits 7, 6, 5 enable capture, compare and overflow interrupts when one.
// - compare pin takeover (bit 4) makes the port pin show the compare level.
// - capture pin takeover (bit 3) claims the pin; capture works from the pin either way.
// - edge select (bit 1) picks rising when one, falling when zero; reset leaves it.
// - output level bit is loaded into the level register at the next compare match.
// - status is read only, flags in bits 7..5, bits 4..0 zero, all reset zero.
// - capture flag sets on a selected edge; clears by status access then capture low.
// - compare flag sets on compare match; clears by status access then compare low.
// - overflow flag sets on all-ones to zero; clears by status access then counter low.
// - clearing needs status access while set, then the data access; status alone keeps it.
// - reads of the alternate counter copy never clear the overflow flag.
// - in wait mode the timer keeps running and an enabled interrupt wakes the part.
// - in stop the counter halts and holds; reset forces it to its preset.
// - an edge in stop arms capture silently; wake by interrupt shows it; reset discards it.
// - the 16-bit counter steps once every four bus clock cycles.

`default_nettype none

package tccs_pkg;

  localparam int unsigned CNT_W = 16;
  localparam int unsigned PRESCALE_DIV = 4;
  localparam logic [15:0] CNT_PRESET = 16'hfffc;
  localparam logic [15:0] CNT_MAX = 16'hffff;

  // printed offsets are register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'h0a;
  localparam logic [7:0] IDX_FLAGS = 8'h0b;
  localparam logic [7:0] IDX_CAP_HI = 8'h0c;
  localparam logic [7:0] IDX_CAP_LO = 8'h0d;
  localparam int unsigned IDX_LSB = 2;

  // flag vector positions
  localparam int unsigned FLAG_N = 3;
  localparam int unsigned FLAG_OVF = 0;
  localparam int unsigned FLAG_CMP = 1;
  localparam int unsigned FLAG_CAP = 2;
  localparam int unsigned FLAG_SHIFT = 5;

  localparam logic [7:0] CTRL_RST = 8'h00;

  typedef struct packed {
    logic capIrqEnable;
    logic cmpIrqEnable;
    logic ovfIrqEnable;
    logic comparePinTakeover;
    logic capturePinTakeover;
    logic unused;
    logic edgeSelect;
    logic outputLevelBit;
  } tccs_ctrl_t;

  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_STOPPED = 3'b010,
    ST_ARMED = 3'b100
  } tccs_stop_t;

endpackage

`default_nettype wire

/* tccs_top.sv */
// capture, control and status part of the 16-bit free-running timer
// assumes an ahb-lite master on ref_clk and the compare/counter paths elsewhere
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`default_nettype none

module tccs_top #(
  parameter int unsigned PRESCALE = tccs_pkg::PRESCALE_DIV
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic capturePinIn,
  input wire logic gpioB0Out,
  input wire logic gpioB0Dir,
  output logic comparePinOut,
  output logic comparePinOe_n,
  output logic capturePinClaim,
  input wire logic compareMatch,
  input wire logic compareLowAccess,
  input wire logic counterLowAccess,
  input wire logic waitMode,
  input wire logic stopMode,
  output logic [15:0] counterValue,
  output logic timerIrq,
  output logic wakeReq
);

  // ***************************************************************
  // reset release
  // ***************************************************************
  logic rstSync1_q;
  logic rstN;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rstSync1_q <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rstN <= rstSync1_q;
    end
  end

  // ***************************************************************
  // bus slave
  // ***************************************************************
  tccs_pkg::tccs_ctrl_t ctrl_q;
  logic edgeSel_q;
  logic [tccs_pkg::FLAG_N-1:0] flags_q;
  logic [15:0] capVal_q;
  logic [15:0] cnt_q;
  logic busSel;
  logic [7:0] idx;
  logic flagsAccess;
  logic capHiRead;
  logic capLoRead;
  logic wrCtrl_q;
  logic [7:0] ctrlRead;
  logic [7:0] rdByte;

  assign busSel = hsel & htrans[1] & hready;
  assign idx = haddr[tccs_pkg::IDX_LSB +: 8];
  assign flagsAccess = busSel & (idx == tccs_pkg::IDX_FLAGS);
  assign capHiRead = busSel & !hwrite & (idx == tccs_pkg::IDX_CAP_HI);
  assign capLoRead = busSel & !hwrite & (idx == tccs_pkg::IDX_CAP_LO);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_comb begin
    ctrlRead = ctrl_q;
    ctrlRead[1] = edgeSel_q;
    ctrlRead[2] = 1'b0;
    case (idx)
      tccs_pkg::IDX_CTRL: rdByte = ctrlRead;
      tccs_pkg::IDX_FLAGS: rdByte = {flags_q, 5'h00};
      tccs_pkg::IDX_CAP_HI: rdByte = capVal_q[15:8];
      tccs_pkg::IDX_CAP_LO: rdByte = capVal_q[7:0];
      default: rdByte = 8'h00;
    endcase
  end

  // read data is sampled in the address phase so side effects line up with it
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      hrdata <= 32'h00000000;
    end else if (clkEn && busSel && !hwrite) begin
      hrdata <= {24'h000000, rdByte};
    end
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      wrCtrl_q <= 1'b0;
    end else if (clkEn && hready) begin
      wrCtrl_q <= busSel & hwrite & (idx == tccs_pkg::IDX_CTRL);
    end
  end

  // ***************************************************************
  // control register
  // ***************************************************************
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      ctrl_q <= tccs_pkg::CTRL_RST;
    end else if (clkEn && wrCtrl_q) begin
      ctrl_q <= hwdata[7:0];
      ctrl_q.unused <= 1'b0;
      ctrl_q.edgeSelect <= 1'b0;
    end
  end

  // edge select lives outside reset on purpose
  always_ff @(posedge ref_clk) begin
    if (clkEn && wrCtrl_q) begin
      edgeSel_q <= hwdata[1];
    end
  end

  // ***************************************************************
  // prescaler and counter
  // ***************************************************************
  localparam int unsigned PRE_W = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PRESCALE - 1);
  logic [PRE_W-1:0] pre_q;
  logic tick;

  assign tick = clkEn & !stopMode & (pre_q == PRE_LAST);

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      pre_q <= '0;
    end else if (clkEn && !stopMode) begin
      pre_q <= (pre_q == PRE_LAST) ? '0 : pre_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      cnt_q <= tccs_pkg::CNT_PRESET;
    end else if (tick) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  assign counterValue = cnt_q;

  // ***************************************************************
  // capture input sync and edge detect
  // ***************************************************************
  logic capSync1_q;
  logic capSync2_q;
  logic capPrev_q;
  logic [2:0] capLive_q;
  logic [15:0] hist1_q;
  logic [15:0] hist2_q;
  logic capEdge;
  logic [15:0] capSample;

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      capSync1_q <= 1'b0;
      capSync2_q <= 1'b0;
      capPrev_q <= 1'b0;
      capLive_q <= '0;
    end else if (clkEn) begin
      capSync1_q <= capturePinIn;
      capSync2_q <= capSync1_q;
      capPrev_q <= capSync2_q;
      capLive_q <= {capLive_q[1:0], 1'b1};
    end
  end

  // count history so the sample lines up with the edge before the pin moved
  always_ff @(posedge ref_clk) begin
    if (clkEn) begin
      hist1_q <= cnt_q;
      hist2_q <= hist1_q;
    end
  end

  // no edge until the history holds real samples: a pin high at reset is no edge
  assign capEdge = capLive_q[2] &
    (edgeSel_q ? (capSync2_q & !capPrev_q) : (!capSync2_q & capPrev_q));
  assign capSample = hist2_q + 16'h0001;

  // ***************************************************************
  // stop handling
  // ***************************************************************
  tccs_pkg::tccs_stop_t stop_q;
  logic [15:0] pend_q;
  logic capNormal;
  logic deliver;
  logic inhibit_q;

  assign capNormal = capEdge & !stopMode;
  assign deliver = (stop_q == tccs_pkg::ST_ARMED) & !stopMode;

  // reset always returns here, so a pending stop capture is simply lost
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      stop_q <= tccs_pkg::ST_RUN;
    end else if (clkEn) begin
      case (stop_q)
        tccs_pkg::ST_RUN: begin
          if (stopMode) begin
            stop_q <= capEdge ? tccs_pkg::ST_ARMED : tccs_pkg::ST_STOPPED;
          end
        end
        tccs_pkg::ST_STOPPED: begin
          if (!stopMode) begin
            stop_q <= tccs_pkg::ST_RUN;
          end else if (capEdge) begin
            stop_q <= tccs_pkg::ST_ARMED;
          end
        end
        tccs_pkg::ST_ARMED: begin
          if (!stopMode) begin
            stop_q <= tccs_pkg::ST_RUN;
          end
        end
        default: stop_q <= tccs_pkg::ST_RUN;
      endcase
    end
  end

  // only the first edge in stop is kept
  always_ff @(posedge ref_clk) begin
    if (clkEn && stopMode && capEdge && stop_q != tccs_pkg::ST_ARMED) begin
      pend_q <= capSample;
    end
  end

  // ***************************************************************
  // capture value
  // ***************************************************************
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      inhibit_q <= 1'b0;
    end else if (clkEn) begin
      if (capLoRead) begin
        inhibit_q <= 1'b0;
      end else if (capHiRead) begin
        inhibit_q <= 1'b1;
      end
    end
  end

  // no reset: contents survive reset; a low read alone never inhibits
  always_ff @(posedge ref_clk) begin
    if (clkEn) begin
      if (deliver) begin
        capVal_q <= pend_q;
      end else if (capNormal && !inhibit_q) begin
        capVal_q <= capSample;
      end
    end
  end

  // ***************************************************************
  // status flags
  // ***************************************************************
  logic [tccs_pkg::FLAG_N-1:0] flagSet;
  logic [tccs_pkg::FLAG_N-1:0] lowAccess;
  logic [tccs_pkg::FLAG_N-1:0] arm_q;

  assign flagSet[tccs_pkg::FLAG_CAP] = capNormal | deliver;
  assign flagSet[tccs_pkg::FLAG_CMP] = compareMatch;
  assign flagSet[tccs_pkg::FLAG_OVF] = tick & (cnt_q == tccs_pkg::CNT_MAX);
  assign lowAccess[tccs_pkg::FLAG_CAP] = capLoRead;
  assign lowAccess[tccs_pkg::FLAG_CMP] = compareLowAccess;
  // alternate counter reads never raise this strobe
  assign lowAccess[tccs_pkg::FLAG_OVF] = counterLowAccess;

  genvar gi;
  generate
    for (gi = 0; gi < tccs_pkg::FLAG_N; gi++) begin : g_flag
      logic clr;
      assign clr = arm_q[gi] & lowAccess[gi];

      always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
          flags_q[gi] <= 1'b0;
          arm_q[gi] <= 1'b0;
        end else if (clkEn) begin
          // set beats a clear landing in the same cycle
          flags_q[gi] <= flagSet[gi] | (flags_q[gi] & !clr);
          if (clr || !flags_q[gi]) begin
            arm_q[gi] <= 1'b0;
          end else if (flagsAccess) begin
            arm_q[gi] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // ***************************************************************
  // compare level and pins
  // ***************************************************************
  logic level_q;

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      level_q <= 1'b0;
    end else if (clkEn && compareMatch) begin
      level_q <= ctrl_q.outputLevelBit;
    end
  end

  assign comparePinOut = ctrl_q.comparePinTakeover ? level_q : gpioB0Out;
  assign comparePinOe_n = ctrl_q.comparePinTakeover ? 1'b0 : !gpioB0Dir;
  assign capturePinClaim = ctrl_q.capturePinTakeover;

  // ***************************************************************
  // interrupt request
  // ***************************************************************
  assign timerIrq = |(flags_q & {ctrl_q.capIrqEnable, ctrl_q.cmpIrqEnable,
                                 ctrl_q.ovfIrqEnable});
  assign wakeReq = timerIrq & waitMode;

  // ***************************************************************
  // checks
  // ***************************************************************
  AST_PRESCALE: assert property (@(posedge ref_clk) disable iff (!rstN)
    (cnt_q != $past(cnt_q)) |-> ($past(pre_q) == PRE_LAST && $past(clkEn)))
    else $error("counter stepped off the prescaler boundary");

  AST_OVF_SET: assert property (@(posedge ref_clk) disable iff (!rstN)
    (tick && cnt_q == tccs_pkg::CNT_MAX) |=> (flags_q[tccs_pkg::FLAG_OVF] && cnt_q == 16'h0000))
    else $error("rollover did not raise the overflow flag");

  AST_CAP_VALUE: assert property (@(posedge ref_clk) disable iff (!rstN)
    (clkEn && capNormal && !inhibit_q && !deliver) |=> (capVal_q == $past(hist2_q) + 16'h0001))
    else $error("captured value is not one past the preceding count");

  AST_INHIBIT: assert property (@(posedge ref_clk) disable iff (!rstN)
    (inhibit_q && !deliver) |=> $stable(capVal_q))
    else $error("capture copied while high byte read pending");

  AST_STATUS_ALONE: assert property (@(posedge ref_clk) disable iff (!rstN)
    (clkEn && flags_q[tccs_pkg::FLAG_CMP] && !arm_q[tccs_pkg::FLAG_CMP])
      |=> flags_q[tccs_pkg::FLAG_CMP])
    else $error("compare flag cleared without a prior status access");

  AST_BIT2_ZERO: assert property (@(posedge ref_clk) disable iff (!rstN)
    (clkEn && busSel && !hwrite && idx == tccs_pkg::IDX_CTRL) |=> (hrdata[2] == 1'b0))
    else $error("control bit 2 read back as one");

  AST_STOP_HALT: assert property (@(posedge ref_clk) disable iff (!rstN)
    (stopMode [*2]) |-> $stable(cnt_q))
    else $error("counter moved during stop");

  AST_STOP_SILENT: assert property (@(posedge ref_clk) disable iff (!rstN)
    (stopMode && !flags_q[tccs_pkg::FLAG_CAP]) |=> !flags_q[tccs_pkg::FLAG_CAP])
    else $error("capture flag raised during stop");

  AST_LEVEL: assert property (@(posedge ref_clk) disable iff (!rstN)
    (clkEn && compareMatch) |=> (level_q == $past(ctrl_q.outputLevelBit)))
    else $error("level register missed the compare match");

  AST_IRQ: assert property (@(posedge ref_clk) disable iff (!rstN)
    (flags_q[tccs_pkg::FLAG_CAP] && ctrl_q.capIrqEnable) |-> timerIrq)
    else $error("enabled capture flag without interrupt request");

endmodule

`default_nettype wire

/* tccs_pin_model.sv */
// far-side model: capture pin source and the pad behind the compare pin
// assumes the bench sets capLvl right after a rising bus clock edge
`default_nettype none

module tccs_pin_model (
  input wire logic capLvl,
  input wire logic comparePinOut,
  input wire logic comparePinOe_n,
  output wire logic capturePinIn,
  output wire logic padLevel
);
  // ****************************************
  // pin levels
  // ****************************************
  logic lastDrv = 1'b0;

  // the edge lands 3 ns after the rising bus clock edge, before the falling one
  assign #3 capturePinIn = capLvl;

  always @(comparePinOut, comparePinOe_n) begin
    if (!comparePinOe_n) begin
      lastDrv = comparePinOut;
    end
  end

  // released pad shows the inverse, so a stale level never passes
  assign padLevel = comparePinOe_n ? ~lastDrv : comparePinOut;
endmodule

`default_nettype wire

/* tccs_tb.sv */
// self-checking bench for the timer capture, control and status block
// assumes tccs_pkg, tccs_top and tccs_pin_model are compiled before it
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CTRL = tccs_pkg::IDX_CTRL;
  localparam logic [7:0] FLG = tccs_pkg::IDX_FLAGS;
  localparam logic [7:0] CHI = tccs_pkg::IDX_CAP_HI;
  localparam logic [7:0] CLO = tccs_pkg::IDX_CAP_LO;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic hreadyout;
  logic gpioB0Out = 1'b0;
  logic gpioB0Dir = 1'b0;
  logic compareMatch = 1'b0;
  logic compareLowAccess = 1'b0;
  logic counterLowAccess = 1'b0;
  logic waitMode = 1'b0;
  logic stopMode = 1'b0;
  logic capLvl = 1'b0;
  logic comparePinOut, comparePinOe_n, capturePinClaim, timerIrq, wakeReq;
  wire logic capturePinIn;
  wire logic padLevel;
  logic [15:0] counterValue, cv, capSeen, keep;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;

  tccs_top tccs_top_inst (
    .ref_clk(ref_clk), .nrst(nrst), .clkEn(1'b1), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .capturePinIn(capturePinIn),
    .gpioB0Out(gpioB0Out), .gpioB0Dir(gpioB0Dir), .comparePinOut(comparePinOut),
    .comparePinOe_n(comparePinOe_n), .capturePinClaim(capturePinClaim),
    .compareMatch(compareMatch), .compareLowAccess(compareLowAccess),
    .counterLowAccess(counterLowAccess), .waitMode(waitMode), .stopMode(stopMode),
    .counterValue(counterValue), .timerIrq(timerIrq), .wakeReq(wakeReq)
  );

  tccs_pin_model tccs_pin_model_inst (
    .capLvl(capLvl), .comparePinOut(comparePinOut), .comparePinOe_n(comparePinOe_n),
    .capturePinIn(capturePinIn), .padLevel(padLevel)
  );

  // ****************************************
  // clock, timeout and shared tasks
  // ****************************************
  always #4 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge ref_clk);
    htrans <= 2'h2;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, idx, 32'h0);
    chk("register", e, rd & m);
  endtask

  // one-cycle strobe: 0 compare match, 1 compare low, 2 counter low
  task automatic strobe(input int k);
    @(posedge ref_clk);
    compareMatch <= (k == 0);
    compareLowAccess <= (k == 1);
    counterLowAccess <= (k == 2);
    @(posedge ref_clk);
    {compareMatch, compareLowAccess, counterLowAccess} <= 3'h0;
    repeat (2) @(posedge ref_clk);
  endtask

  // pin change placed just after a counter step, so the count is steady around it
  task automatic pin(input logic lvl);
    cv = counterValue;
    if (!stopMode) begin
      do @(negedge ref_clk); while (counterValue === cv);
    end
    @(posedge ref_clk);
    capLvl <= lvl;
    #1 cv = counterValue + 16'h1;
    repeat (8) @(posedge ref_clk);
  endtask

  task automatic cap(input logic [15:0] e);
    bus(1'b0, CHI, 32'h0);
    capSeen[15:8] = rd[7:0];
    bus(1'b0, CLO, 32'h0);
    capSeen[7:0] = rd[7:0];
    chk("capture", {16'h0, e}, {16'h0, capSeen});
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rdchk(FLG, 32'hff, 32'h0);
    rdchk(CTRL, 32'hfd, 32'h0);
    rdchk(8'h20, 32'hffffffff, 32'h0);
    $display("reset test done");
    repeat (30) @(posedge ref_clk);
    strobe(2);
    rdchk(FLG, 32'hff, 32'h20);
    rdchk(FLG, 32'hff, 32'h20);
    bus(1'b1, CTRL, 32'h20);
    waitMode <= 1'b1;
    #1 chk("irq", 32'h1, {31'h0, timerIrq});
    chk("wake", 32'h1, {31'h0, wakeReq});
    @(posedge ref_clk);
    waitMode <= 1'b0;
    strobe(2);
    rdchk(FLG, 32'hff, 32'h0);
    chk("irq", 32'h0, {31'h0, timerIrq});
    $display("overflow test done");
    bus(1'b1, CTRL, 32'hff);
    rdchk(CTRL, 32'hff, 32'hfb);
    chk("oe", 32'h0, {31'h0, comparePinOe_n});
    strobe(0);
    chk("pad", 32'h1, {31'h0, padLevel});
    rdchk(FLG, 32'hff, 32'h40);
    bus(1'b1, CTRL, 32'hfa);
    #1 chk("pad", 32'h1, {31'h0, padLevel});
    strobe(0);
    chk("pad", 32'h0, {31'h0, padLevel});
    strobe(1);
    rdchk(FLG, 32'hff, 32'h0);
    gpioB0Dir <= 1'b1;
    gpioB0Out <= 1'b1;
    bus(1'b1, CTRL, 32'h02);
    #1 chk("pad", 32'h1, {31'h0, padLevel});
    chk("claim", 32'h0, {31'h0, capturePinClaim});
    bus(1'b1, CTRL, 32'h0a);
    #1 chk("claim", 32'h1, {31'h0, capturePinClaim});
    $display("compare test done");
    pin(1'b1);
    rdchk(FLG, 32'hff, 32'h80);
    cap(cv);
    rdchk(FLG, 32'hff, 32'h0);
    pin(1'b0);
    rdchk(FLG, 32'hff, 32'h0);
    pin(1'b1);
    pin(1'b0);
    pin(1'b1);
    keep = cv;
    cap(keep);
    bus(1'b0, CHI, 32'h0);
    pin(1'b0);
    pin(1'b1);
    bus(1'b0, CLO, 32'h0);
    chk("capture low", {24'h0, keep[7:0]}, rd & 32'hff);
    pin(1'b0);
    pin(1'b1);
    cap(cv);
    bus(1'b0, CLO, 32'h0);
    pin(1'b0);
    pin(1'b1);
    cap(cv);
    bus(1'b1, CTRL, 32'h08);
    pin(1'b0);
    rdchk(FLG, 32'h80, 32'h80);
    cap(cv);
    $display("capture test done");
    pin(1'b1);
    rdchk(FLG, 32'h80, 32'h0);
    stopMode <= 1'b1;
    repeat (4) @(posedge ref_clk);
    keep = counterValue;
    pin(1'b0);
    rdchk(FLG, 32'h80, 32'h0);
    chk("count", {16'h0, keep}, {16'h0, counterValue});
    stopMode <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rdchk(FLG, 32'h80, 32'h80);
    cap(cv);
    keep = cv;
    bus(1'b1, CTRL, 32'h02);
    stopMode <= 1'b1;
    @(posedge ref_clk);
    pin(1'b1);
    nrst <= 1'b0;
    stopMode <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("count", 32'hfffc, {16'h0, counterValue});
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rdchk(FLG, 32'h80, 32'h0);
    rdchk(CTRL, 32'hff, 32'h02);
    cap(keep);
    $display("stop test done");
    final_report();
  end
endmodule

`default_nettype wire
